//--- rtl/pwvc_ctrl.sv
// PWM value registers, reload overrun flags and pair correction control
`timescale 1ns/1ps
`include "pwvc_params.svh"
//
// Contract
// - Six value registers hold 16-bit signed pulse widths in PWM clocks.
// - Zero or negative effective width holds the output low all period.
// - Width at or above modulus holds the output high all period.
// - Active output is logic high, inactive logic low.
// - Writes land in buffer; loaded at reload after load-ok; reads buffer.
// - Overrun enables at bits 2,1,0 gate generators C,B,A; 1 enables.
// - Flags cleared by writing 1; 0 leaves them; always readable.
// - Flag C set on reload C without load-ok C or global.
// - Flag B set on reload B without load-ok B or global.
// - Flag A follows reload-source select 01 A, 10 B, 11 C; 00 none.
// - Direction correction only in center-aligned complementary operation.
// - Direction bit set: even value counting up, odd counting down.
// - Direction bits buffered, take effect next reload regardless of load-ok.
// - Edge bits 5,4,3 for pairs 4/5,2/3,0/1 override direction correction.
// - Edge control ANDs inverted even and odd pulses before complementary logic.
// - Edge control: one value activates pulse, the other deactivates it.
// - Edge bits buffered, effective next reload after load-ok.
// - Polarity bit 0 selects even value, 1 odd value, for next cycle.
module pwvc_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire pwvc_pkg::pwvc_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire pwvc_pkg::pwvc_timing_t timing,
  input wire logic [2:0][15:0] counter,
  input wire logic [2:0][15:0] modulus,
  output logic [5:0] pair_pulse,
  output logic [2:0] overrun_irq,
  output logic [2:0] load_ok_state
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [5:0][15:0] val_buf_ff;
  logic [5:0][15:0] val_act_ff;
  logic [2:0] roie_ff;
  logic [2:0] roif_ff;
  logic [2:0] icc_buf_ff;
  logic [2:0] icc_act_ff;
  logic [2:0] pec_buf_ff;
  logic [2:0] pec_act_ff;
  logic [2:0] pol_buf_ff;
  logic [2:0] pol_act_ff;
  logic [2:0] ldok_ff;
  logic [1:0] rev_ff;
  logic center_ff;
  logic compl_ff;
  logic [5:0] pulse_ff;
  logic [15:0] rdata_ff;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wr = bus_req.wr;
  wire [3:0] a = bus_req.addr;
  wire [15:0] wd = bus_req.wdata;
  wire is_val = (a <= `PWVC_OFF_VAL5);
  wire wr_roie = wr && (a == `PWVC_OFF_ROIE);
  wire wr_roif = wr && (a == `PWVC_OFF_ROIF);
  wire wr_icctl = wr && (a == `PWVC_OFF_ICCTL);
  wire wr_pol = wr && (a == `PWVC_OFF_POL);
  wire wr_ldok = wr && (a == `PWVC_OFF_LDOK);
  wire wr_mode = wr && (a == `PWVC_OFF_MODE);
  wire [2:0] rld = timing.reload_evt;
  wire [2:0] ok_eff = ldok_ff | timing.glob_ldok;
  // Read selection, registered below
  wire [15:0] rd_mux =
    is_val ? val_buf_ff[a[2:0]] :
    (a == `PWVC_OFF_ROIE) ? {13'h0, roie_ff} :
    (a == `PWVC_OFF_ROIF) ? {13'h0, roif_ff} :
    (a == `PWVC_OFF_ICCTL) ? {10'h0, pec_buf_ff, icc_buf_ff} :
    (a == `PWVC_OFF_POL) ? {13'h0, pol_buf_ff} :
    (a == `PWVC_OFF_LDOK) ? {13'h0, ldok_ff} :
    (a == `PWVC_OFF_MODE) ? {12'h0, compl_ff, center_ff, rev_ff} : 16'h0000;

  // ------------------------------------------------------------
  // Overrun events
  // ------------------------------------------------------------
  pwvc_pkg::pwvc_rev_t src;
  assign src = (rev_ff == 2'h1) ? pwvc_pkg::SRC_A :
               (rev_ff == 2'h2) ? pwvc_pkg::SRC_B :
               (rev_ff == 2'h3) ? pwvc_pkg::SRC_C : pwvc_pkg::SRC_NONE;
  logic ovr_a;
  always_comb begin
    unique case (src)
      pwvc_pkg::SRC_A: ovr_a = rld[0] && !ok_eff[0];
      pwvc_pkg::SRC_B: ovr_a = rld[1] && !ok_eff[1];
      pwvc_pkg::SRC_C: ovr_a = rld[2] && !ok_eff[2];
      default: ovr_a = 1'b0;
    endcase
  end
  wire [2:0] ovr_set = {rld[2] && !ok_eff[2], rld[1] && !ok_eff[1], ovr_a};
  wire [2:0] nxt_roif = ovr_set | (roif_ff & ~(wr_roif ? wd[2:0] : 3'h0));

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      roie_ff <= 3'h0;
      roif_ff <= 3'h0;
      icc_buf_ff <= 3'h0;
      pec_buf_ff <= 3'h0;
      pol_buf_ff <= 3'h0;
      rev_ff <= 2'h0;
      center_ff <= 1'b0;
      compl_ff <= 1'b0;
      rdata_ff <= `PWVC_RST_VAL;
    end else if (clk_en) begin
      if (wr_roie) roie_ff <= wd[2:0];
      roif_ff <= nxt_roif;
      if (wr_icctl) begin
        icc_buf_ff <= wd[2:0];
        pec_buf_ff <= wd[5:3];
      end
      if (wr_pol) pol_buf_ff <= wd[2:0];
      if (wr_mode) begin
        rev_ff <= wd[1:0];
        center_ff <= wd[`PWVC_BIT_CENTER];
        compl_ff <= wd[`PWVC_BIT_COMPL];
      end
      rdata_ff <= bus_req.rd ? rd_mux : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Per-generator buffering and load
  // ------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : gen_pair
    always_ff @(posedge mclk) begin
      if (reset) begin
        val_buf_ff[2*g] <= `PWVC_RST_VAL;
        val_buf_ff[2*g+1] <= `PWVC_RST_VAL;
        val_act_ff[2*g] <= `PWVC_RST_VAL;
        val_act_ff[2*g+1] <= `PWVC_RST_VAL;
        icc_act_ff[g] <= 1'b0;
        pec_act_ff[g] <= 1'b0;
        pol_act_ff[g] <= 1'b0;
        ldok_ff[g] <= 1'b0;
      end else if (clk_en) begin
        // software writes go to the buffer
        if (wr && is_val && (a == 4'(2*g))) val_buf_ff[2*g] <= wd;
        if (wr && is_val && (a == 4'(2*g+1))) val_buf_ff[2*g+1] <= wd;
        if (rld[g]) begin
          // direction and polarity load regardless of load-ok
          icc_act_ff[g] <= icc_buf_ff[g];
          pol_act_ff[g] <= pol_buf_ff[g];
        end
        if (rld[g] && ok_eff[g]) begin
          val_act_ff[2*g] <= val_buf_ff[2*g];
          val_act_ff[2*g+1] <= val_buf_ff[2*g+1];
          pec_act_ff[g] <= pec_buf_ff[g];
          ldok_ff[g] <= 1'b0;
        end else if (wr_ldok && wd[g]) begin
          ldok_ff[g] <= 1'b1;
        end
      end
    end

    wire signed [15:0] ve = val_act_ff[2*g];
    wire signed [15:0] vo = val_act_ff[2*g+1];
    wire signed [15:0] cnt = counter[g];
    wire signed [15:0] mdl = modulus[g];
    wire pe = (ve <= 16'sh0) ? 1'b0 : (ve >= mdl) ? 1'b1 : (cnt < ve);
    wire po = (vo <= 16'sh0) ? 1'b0 : (vo >= mdl) ? 1'b1 : (cnt < vo);
    wire use_dir = icc_act_ff[g] && center_ff && compl_ff;
    wire sel_odd = use_dir ? !timing.count_up[g] : pol_act_ff[g];
    // edge control ANDs inverted-even and odd windows
    wire pec_on = pec_act_ff[g] && compl_ff;
    wire p_sel = pec_on ? (!pe && po) : (sel_odd ? po : pe);
    wire p_ind_odd = compl_ff ? p_sel : po;

    always_ff @(posedge mclk) begin
      if (reset) begin
        pulse_ff[2*g] <= 1'b0;
        pulse_ff[2*g+1] <= 1'b0;
      end else if (clk_en) begin
        pulse_ff[2*g] <= compl_ff ? p_sel : pe;
        pulse_ff[2*g+1] <= p_ind_odd;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus_rdata = rdata_ff;
  assign pair_pulse = pulse_ff;
  assign overrun_irq = roif_ff & roie_ff;
  assign load_ok_state = ldok_ff;

endmodule

//--- rtl/pwvc_params.svh
// Register offsets, field positions, reset values and widths for the PWM value block
`ifndef PWVC_PARAMS_SVH
`define PWVC_PARAMS_SVH
`define PWVC_ADDR_W 4
`define PWVC_OFF_VAL0 4'h0
`define PWVC_OFF_VAL5 4'h5
`define PWVC_OFF_ROIE 4'h6
`define PWVC_OFF_ROIF 4'h7
`define PWVC_OFF_ICCTL 4'h8
`define PWVC_OFF_POL 4'h9
`define PWVC_OFF_LDOK 4'hA
`define PWVC_OFF_MODE 4'hB
`define PWVC_BIT_GEN_A 0
`define PWVC_BIT_GEN_B 1
`define PWVC_BIT_GEN_C 2
`define PWVC_BIT_PEC_LO 3
`define PWVC_BIT_REV_LO 0
`define PWVC_BIT_CENTER 2
`define PWVC_BIT_COMPL 3
`define PWVC_RST_VAL 16'h0000
`define PWVC_RST_BYTE 8'h00
`endif

//--- rtl/pwvc_pkg.sv
// Types shared by the PWM value and correction block
package pwvc_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pwvc_bus_req_t;
  typedef struct packed {
    logic [2:0] reload_evt;
    logic [2:0] count_up;
    logic [2:0] glob_ldok;
  } pwvc_timing_t;
  typedef enum logic [3:0] {
    SRC_NONE = 4'b0001,
    SRC_A = 4'b0010,
    SRC_B = 4'b0100,
    SRC_C = 4'b1000
  } pwvc_rev_t;
endpackage

//--- testbench/pwvc_ctrl_properties.sv
// Port assertions for the PWM value block
`timescale 1ns/1ps
module pwvc_ctrl_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire pwvc_pkg::pwvc_bus_req_t bus_req,
  input wire pwvc_pkg::pwvc_timing_t timing,
  input wire logic [2:0] overrun_irq,
  input wire logic [2:0] load_ok_state
);
  wire [2:0] ev = timing.reload_evt;
  wire [3:0] wa = (clk_en && bus_req.wr) ? bus_req.addr : 4'hF;
  wire [2:0] wd = bus_req.wdata[2:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_miss(g); clk_en && ev[g] && !load_ok_state[g] && !timing.glob_ldok[g]; endsequence
  sequence s_en(g); wa == 4'h6 && wd[g]; endsequence
  ldok_set_a: assert property (wa == 4'hA && wd[0] && !ev[0] |=> load_ok_state[0]) else $error("no ldok");
  ldok_hold_a: assert property (load_ok_state[0] && !ev[0] |=> load_ok_state[0]) else $error("ldok lost");
  ldok_clear_a: assert property (clk_en && ev[0] && load_ok_state[0] && wa != 4'hA |=> !load_ok_state[0])
    else $error("ldok kept");
  flag_clear_a: assert property (wa == 4'h7 && wd == 3'h7 && !ev |=> !overrun_irq) else $error("flags kept");
  irq_mask_a: assert property (wa == 4'h6 && wd == 3'h0 |=> !overrun_irq) else $error("irq on");
  irq_keep_a: assert property (wa == 4'hF |=> (overrun_irq & $past(overrun_irq)) == $past(overrun_irq))
    else $error("irq dropped");
  ovr_b_a: assert property (s_miss(1) ##1 s_en(1) |=> overrun_irq[1]) else $error("no overrun B");
  ovr_c_a: assert property (s_miss(2) ##1 s_en(2) |=> overrun_irq[2]) else $error("no overrun C");
endmodule
bind pwvc_ctrl pwvc_ctrl_properties i_pwvc_ctrl_properties (.mclk(mclk), .reset(reset), .clk_en(clk_en),
  .bus_req(bus_req), .timing(timing), .overrun_irq(overrun_irq), .load_ok_state(load_ok_state));

//--- testbench/pwvc_gate_model.sv
// Gate driver stand-in latching the six outputs
`timescale 1ns/1ps
module pwvc_gate_model (
  input wire logic mclk,
  input wire logic [5:0] gate_in,
  output logic [5:0] gate_seen
);
  always_ff @(posedge mclk) gate_seen <= gate_in;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the PWM value block
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  pwvc_pkg::pwvc_bus_req_t bus_req = '0;
  pwvc_pkg::pwvc_timing_t timing = '0;
  logic [15:0] bus_rdata;
  logic [5:0] pair_pulse, gate;
  logic [2:0] overrun_irq, load_ok_state;
  int fails = 0, check_count = 0;
  always #2 mclk = ~mclk;
  pwvc_ctrl i_pwvc_ctrl (.mclk(mclk), .reset(reset), .clk_en(clk_en), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .timing(timing), .counter({3{16'h0010}}), .modulus({3{16'h0064}}), .pair_pulse(pair_pulse),
    .overrun_irq(overrun_irq), .load_ok_state(load_ok_state));
  pwvc_gate_model i_pwvc_gate_model (.mclk(mclk), .gate_in(pair_pulse), .gate_seen(gate));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("%0d checks %0d fails", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic [3:0] a, input logic [15:0] d, input logic w);
    bus_req <= '{a, d, w, !w};
    @(posedge mclk);
    bus_req <= '{a, d, 1'b0, 1'b0};
    if (!w) #1 chk(bus_rdata, d);
    @(posedge mclk);
  endtask
  task automatic fire(input logic [2:0] e);
    timing.reload_evt <= e;
    @(posedge mclk);
    timing.reload_evt <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic t_load();
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 6; i++) acc(4'(i), p ? 16'h7FFF : (i[0] ? 16'hFF00 : 16'h0000), 1'b1);
      if (p != 1) acc(4'hA, 16'h0007, 1'b1);
      fire(3'h7);
      repeat (4) @(posedge mclk);
      chk({10'h0, gate}, p == 2 ? 16'h003F : 16'h0000);
    end
    acc(4'h1, 16'h7FFF, 1'b0);
    $display("load done");
  endtask
  task automatic t_flags();
    for (int s = 0; s < 4; s++) begin
      acc(4'hB, 16'(s), 1'b1);
      fire(3'h7);
      acc(4'h7, s ? 16'h0007 : 16'h0006, 1'b0);
      acc(4'h7, 16'h0002, 1'b1);
      acc(4'h7, s ? 16'h0005 : 16'h0004, 1'b0);
      acc(4'h7, 16'h0007, 1'b1);
    end
    timing.reload_evt <= 3'h7;
    @(posedge mclk);
    timing.reload_evt <= 3'h0;
    acc(4'h6, 16'h0006, 1'b1);
    chk({13'h0, overrun_irq}, 16'h0006);
    acc(4'h6, 16'h0000, 1'b1);
    acc(4'h7, 16'h0007, 1'b1);
    timing.glob_ldok <= 3'h7;
    fire(3'h7);
    acc(4'h7, 16'h0000, 1'b0);
    $display("flags done");
  endtask
  task automatic t_corr();
    timing.glob_ldok <= 3'h0;
    timing.count_up <= 3'h7;
    acc(4'hB, 16'h0008, 1'b1);
    for (int i = 0; i < 6; i++) acc(4'(i), i[0] ? 16'h0020 : 16'h0008, 1'b1);
    acc(4'hA, 16'h0007, 1'b1);
    fire(3'h7);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h0000);
    acc(4'h9, 16'h0007, 1'b1);
    fire(3'h7);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h003F);
    acc(4'hB, 16'h000C, 1'b1);
    acc(4'h8, 16'h0007, 1'b1);
    fire(3'h7);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h0000);
    timing.count_up <= 3'h0;
    repeat (3) @(posedge mclk);
    chk({10'h0, gate}, 16'h003F);
    timing.count_up <= 3'h7;
    acc(4'hB, 16'h0008, 1'b1);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h003F);
    acc(4'h9, 16'h0000, 1'b1);
    acc(4'h8, 16'h0038, 1'b1);
    fire(3'h7);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h0000);
    acc(4'hA, 16'h0007, 1'b1);
    chk({13'h0, load_ok_state}, 16'h0007);
    fire(3'h7);
    repeat (2) @(posedge mclk);
    chk({10'h0, gate}, 16'h003F);
    chk({13'h0, load_ok_state}, 16'h0000);
    clk_en <= 1'b0;
    acc(4'h9, 16'h0005, 1'b1);
    clk_en <= 1'b1;
    acc(4'h9, 16'h0000, 1'b0);
    $display("correction done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_load();
    t_flags();
    t_corr();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    fails++;
    print_verdict();
  end
endmodule
